/* hw/tel_map_top.sv */
// Purpose: maps button touch and release events onto autolight outputs
// Assumes: touch levels from the sensing engine arrive asynchronously
// Notes: registers reached over axi4-lite, word per register
`timescale 1ns/1ps
`default_nettype none
module tel_map_top #(
  parameter int NB = tel_pkg::NUM_BTN,
  parameter int NO = tel_pkg::NUM_OUT
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] touch_i,
  input wire logic doze_i,
  output logic [1:0] light_o,
  output logic wake_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] touch_s;
  logic [7:0] touch_d_r;
  logic [7:0] press;
  logic [7:0] rel;
  logic [7:0] light_sel_r;
  logic [7:0] button_group_zero_mask_r;
  logic [7:0] button_group_one_mask_r;
  logic [2:0] wake_len_r;
  logic [23:0] wake_keys_r;
  logic [1:0] auto_en_r;
  logic [2:0] wake_pos;
  logic grp0_press;
  logic grp0_rel;
  logic grp1_press;
  logic grp1_rel;
  logic [7:0] aw_addr_r;
  logic aw_full_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_full_r;
  logic do_write;
  logic [5:0] w_idx;
  logic w_hit;
  logic [5:0] r_idx;
  logic [31:0] r_val;
  logic r_hit;

  tel_in_sync #(
    .W(NB)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .d_i(touch_i),
    .q_o(touch_s)
  );

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      touch_d_r <= 8'h00;
    end
    else
    begin
      touch_d_r <= touch_s;
    end
  end
  assign press = touch_s & ~touch_d_r;
  assign rel = ~touch_s & touch_d_r;

  // group events, mask bit n gates button n
  assign grp0_press = |(press & button_group_zero_mask_r);
  assign grp0_rel = |(rel & button_group_zero_mask_r);
  assign grp1_press = |(press & button_group_one_mask_r);
  assign grp1_rel = |(rel & button_group_one_mask_r);

  // every output evaluated in the same cycle so shared events switch together
  genvar g;
  generate
    for (g = 0; g < NO; g++)
    begin : g_out
      logic [3:0] sel;
      logic on_ev;
      logic off_ev;
      assign sel = light_sel_r[g*4 +: 4];
      always_comb
      begin
        on_ev = 1'b0;
        off_ev = 1'b0;
        if (sel <= tel_pkg::SEL_BTN_MAX)
        begin
          on_ev = press[sel[2:0]];
          off_ev = rel[sel[2:0]];
        end
        else if (sel == tel_pkg::SEL_GRP0)
        begin
          on_ev = grp0_press;
          off_ev = grp0_rel;
        end
        else if (sel == tel_pkg::SEL_GRP1)
        begin
          on_ev = grp1_press;
          off_ev = grp1_rel;
        end
        // 0x8..0xB and 0xE, 0xF select nothing
      end
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          light_o[g] <= 1'b0;
        end
        else if (auto_en_r[g])
        begin
          // a press in a group beats a release of another member in the same cycle
          if (on_ev)
          begin
            light_o[g] <= 1'b1;
          end
          else if (off_ev)
          begin
            light_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  tel_wake_seq #(
    .NB(NB)
  ) u_wake (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .doze_i(doze_i),
    .len_i(wake_len_r),
    .keys_i(wake_keys_r),
    .touch_i(touch_s),
    .press_i(press),
    .rel_i(rel),
    .pos_o(wake_pos),
    .wake_o(wake_o)
  );

  // axi write: address and data captured independently
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign w_idx = aw_addr_r[7:2];
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tel_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? tel_pkg::RESP_OKAY : tel_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb
  begin
    case (w_idx)
      tel_pkg::IDX_WAKE_LEN, tel_pkg::IDX_WAKE_54, tel_pkg::IDX_WAKE_32,
      tel_pkg::IDX_WAKE_10, tel_pkg::IDX_LIGHT_SEL, tel_pkg::IDX_GRP0_UP,
      tel_pkg::IDX_GRP0_LO, tel_pkg::IDX_GRP1_UP, tel_pkg::IDX_GRP1_LO,
      tel_pkg::IDX_AUTO_EN, tel_pkg::IDX_STATUS: w_hit = 1'b1;
      default: w_hit = 1'b0;
    endcase
  end

  // register writes, only byte lane 0 carries data
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      light_sel_r <= tel_pkg::RST_SEL;
      button_group_zero_mask_r <= tel_pkg::RST_MASK;
      button_group_one_mask_r <= tel_pkg::RST_MASK;
      wake_len_r <= tel_pkg::RST_WAKE_LEN;
      wake_keys_r <= {3{tel_pkg::RST_KEYS}};
      auto_en_r <= tel_pkg::RST_AUTO_EN;
    end
    else if (do_write && w_strb_r[0])
    begin
      case (w_idx)
        tel_pkg::IDX_WAKE_LEN: wake_len_r <= w_data_r[2:0];
        tel_pkg::IDX_WAKE_54: wake_keys_r[23:16] <= w_data_r[7:0];
        tel_pkg::IDX_WAKE_32: wake_keys_r[15:8] <= w_data_r[7:0];
        tel_pkg::IDX_WAKE_10: wake_keys_r[7:0] <= w_data_r[7:0];
        tel_pkg::IDX_LIGHT_SEL: light_sel_r <= w_data_r[7:0];
        tel_pkg::IDX_GRP0_LO: button_group_zero_mask_r <= w_data_r[7:0];
        tel_pkg::IDX_GRP1_LO: button_group_one_mask_r <= w_data_r[7:0];
        tel_pkg::IDX_AUTO_EN: auto_en_r <= w_data_r[1:0];
        default: ; // upper mask and status writes dropped
      endcase
    end
  end

  // axi read, one cycle to rvalid
  assign s_axi_arready = !s_axi_rvalid;
  assign r_idx = s_axi_araddr[7:2];
  always_comb
  begin
    r_hit = 1'b1;
    r_val = 32'h0000_0000;
    case (r_idx)
      tel_pkg::IDX_WAKE_LEN: r_val = {29'h0, wake_len_r};
      tel_pkg::IDX_WAKE_54: r_val = {24'h0, wake_keys_r[23:16]};
      tel_pkg::IDX_WAKE_32: r_val = {24'h0, wake_keys_r[15:8]};
      tel_pkg::IDX_WAKE_10: r_val = {24'h0, wake_keys_r[7:0]};
      tel_pkg::IDX_LIGHT_SEL: r_val = {24'h0, light_sel_r};
      tel_pkg::IDX_GRP0_UP: r_val = 32'h0000_0000;
      tel_pkg::IDX_GRP0_LO: r_val = {24'h0, button_group_zero_mask_r};
      tel_pkg::IDX_GRP1_UP: r_val = 32'h0000_0000;
      tel_pkg::IDX_GRP1_LO: r_val = {24'h0, button_group_one_mask_r};
      tel_pkg::IDX_AUTO_EN: r_val = {30'h0, auto_en_r};
      tel_pkg::IDX_STATUS: r_val = {16'h0, 3'h0, wake_pos, light_o, touch_s};
      default: r_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tel_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= r_val;
      s_axi_rresp <= r_hit ? tel_pkg::RESP_OKAY : tel_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // tel_map_top
`default_nettype wire

/* hw/tel_pkg.sv */
// Purpose: shared constants for the touch event light mapping block
// Assumes: 8 buttons, 2 mapped outputs, axi4-lite byte addressing
// Notes: printed offsets are not word multiples, so they are indices
package tel_pkg;
  localparam int NUM_BTN = 8;
  localparam int NUM_OUT = 2;
  localparam int ADDR_W = 8;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_WAKE_LEN = 6'h33;
  localparam logic [5:0] IDX_WAKE_54 = 6'h34;
  localparam logic [5:0] IDX_WAKE_32 = 6'h35;
  localparam logic [5:0] IDX_WAKE_10 = 6'h36;
  localparam logic [5:0] IDX_LIGHT_SEL = 6'h3A;
  localparam logic [5:0] IDX_GRP0_UP = 6'h3B;
  localparam logic [5:0] IDX_GRP0_LO = 6'h3C;
  localparam logic [5:0] IDX_GRP1_UP = 6'h3D;
  localparam logic [5:0] IDX_GRP1_LO = 6'h3E;
  localparam logic [5:0] IDX_AUTO_EN = 6'h3F;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  // reset values
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [2:0] RST_WAKE_LEN = 3'h0;
  localparam logic [7:0] RST_KEYS = 8'h00;
  localparam logic [1:0] RST_AUTO_EN = 2'h3;
  // selector codes
  localparam logic [3:0] SEL_BTN_MAX = 4'h7;
  localparam logic [3:0] SEL_GRP0 = 4'hC;
  localparam logic [3:0] SEL_GRP1 = 4'hD;
  // wake length codes, then axi response codes and wake states
  localparam logic [2:0] WAKE_ANY = 3'h0;
  localparam logic [2:0] WAKE_MAX = 3'h6;
  localparam logic [2:0] WAKE_NONE = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TEL_WK_IDLE = 2'b00,
    TEL_WK_HELD = 2'b01
  } tel_wake_st_t;
endpackage

/* hw/tel_in_sync.sv */
// Purpose: three-stage synchroniser with agreement filter per bit
// Assumes: inputs come from another domain
// Notes: stage one feeds only stage two
`timescale 1ns/1ps
`default_nettype none
module tel_in_sync #(
  parameter int W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o <= '0;
    end
    else
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
        begin
          q_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // tel_in_sync
`default_nettype wire

/* hw/tel_wake_seq.sv */
// Purpose: doze to active wake-up key sequence matcher
// Assumes: touch level per button, already synchronised
// Notes: wake pulse is one cycle
`timescale 1ns/1ps
`default_nettype none
module tel_wake_seq #(
  parameter int NB = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic doze_i,
  input wire logic [2:0] len_i,
  input wire logic [23:0] keys_i,
  input wire logic [NB-1:0] touch_i,
  input wire logic [NB-1:0] press_i,
  input wire logic [NB-1:0] rel_i,
  output logic [2:0] pos_o,
  output logic wake_o
);
  tel_pkg::tel_wake_st_t st_r;
  logic [3:0] held_r;
  logic [3:0] key_cur;
  logic good_press;
  logic bad_press;
  assign key_cur = keys_i[pos_o*4 +: 4];
  // reserved key codes can never match
  assign good_press = (key_cur <= tel_pkg::SEL_BTN_MAX) && press_i[key_cur[2:0]];
  assign bad_press = (|press_i) && !good_press;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= tel_pkg::TEL_WK_IDLE;
      held_r <= 4'h0;
      pos_o <= 3'h0;
      wake_o <= 1'b0;
    end
    else
    begin
      wake_o <= 1'b0;
      if (!doze_i || len_i == tel_pkg::WAKE_NONE)
      begin
        st_r <= tel_pkg::TEL_WK_IDLE;
        pos_o <= 3'h0;
      end
      else if (len_i == tel_pkg::WAKE_ANY)
      begin
        wake_o <= |(press_i | rel_i);
      end
      else
      begin
        case (st_r)
          tel_pkg::TEL_WK_IDLE:
          begin
            if (good_press)
            begin
              st_r <= tel_pkg::TEL_WK_HELD;
              held_r <= key_cur;
            end
            else if (bad_press)
            begin
              pos_o <= 3'h0;
            end
          end
          tel_pkg::TEL_WK_HELD:
          begin
            // other events ignored until the key is released
            if (rel_i[held_r[2:0]])
            begin
              st_r <= tel_pkg::TEL_WK_IDLE;
              if (pos_o + 3'h1 >= len_i)
              begin
                wake_o <= 1'b1;
                pos_o <= 3'h0;
              end
              else
              begin
                pos_o <= pos_o + 3'h1;
              end
            end
          end
          default:
          begin
            st_r <= tel_pkg::TEL_WK_IDLE;
          end
        endcase
      end
    end
  end
endmodule // tel_wake_seq
`default_nettype wire

/* tb/tel_touch_model.sv */
// Purpose: behavioural touch sensing engine that reports button touch levels
// Assumes: the bench picks a new lag for each change
// Notes: levels only, no analog behaviour
`timescale 1ns/1ps
`default_nettype none
module tel_touch_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] want_i,
  input wire logic [1:0] lag_i,
  output logic [7:0] touch_o
);
  logic [1:0] cnt_r;
  initial cnt_r = 2'h0;
  initial touch_o = 8'h00;
  // a slow engine holds the old level a few cycles before reporting
  always @(posedge clk_sys_i)
    if (want_i == touch_o) cnt_r <= 2'h0;
    else if (cnt_r >= lag_i) touch_o <= want_i;
    else cnt_r <= cnt_r + 2'h1;
endmodule // tel_touch_model
`default_nettype wire

/* tb/tel_map_properties.sv */
// Purpose: port-level checks for the light mapping block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound onto tel_map_top
`timescale 1ns/1ps
`default_nettype none
module tel_map_props (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [7:0] touch_i,
  input wire logic [1:0] light_o,
  input wire logic wake_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] tprev_r;
  logic [3:0] quiet_r;
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i) tprev_r <= 8'h00;
    else tprev_r <= touch_i;
  // margin of ten covers the sync chain plus the output register
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i) quiet_r <= 4'h0;
    else if (touch_i != tprev_r || (s_axi_wvalid && s_axi_wready)) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  chk_light_quiet: assert property (quiet_r >= 4'hA |-> $stable(light_o))
    else $error("light changed with no touch event");
  chk_reset_dark: assert property ($rose(rst_b_i) |-> light_o == 2'h0 && !wake_o)
    else $error("outputs active right after reset");
  chk_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule // tel_map_props
bind tel_map_top tel_map_props u_props (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .touch_i(touch_i), .light_o(light_o), .wake_o(wake_o),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* tb/tb_touch_event_light_mapping.sv */
// Purpose: self-checking bench for the light mapping block
// Assumes: bench is the bus master, touch model is the sensing engine
// Notes: random masks and lags from a fixed lfsr seed
`timescale 1ns/1ps
`default_nettype none
module tb_touch_event_light_mapping;
  logic clk_sys_i, rst_b_i, doze_i, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] want, awaddr, araddr;
  logic [1:0] lag;
  logic [3:0] wstrb;
  logic [31:0] wdata, rs, rdv;
  wire logic [7:0] touch;
  wire logic [1:0] light, bresp, rresp;
  wire logic wake, awready, wready, bvalid, arready, rvalid;
  wire logic [31:0] rdata;
  int n_mismatch, tests_run, wk, k, i;
  tel_touch_model u_eng (.clk_sys_i(clk_sys_i), .want_i(want), .lag_i(lag), .touch_o(touch));
  tel_map_top DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .touch_i(touch),
    .doze_i(doze_i), .light_o(light), .wake_o(wake), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bready is raised late on purpose so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    if (n == 40)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_sys_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rdv = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    if (n == 40)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic pr(input int b, input logic v);
    int n;
    @(posedge clk_sys_i);
    rs = nx(rs);
    want[b] <= v;
    lag <= rs[1:0];
    // wait for the engine, else a short tap is lost in the agreement filter
    @(posedge clk_sys_i);
    for (n = 0; n < 8 && touch !== want; n++) @(posedge clk_sys_i);
    if (touch !== want)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic wl(input logic [1:0] e, input logic hold);
    int n;
    if (hold) repeat (14) @(posedge clk_sys_i);
    for (n = 0; n < 30 && light !== e; n++) @(posedge clk_sys_i);
    chk("light", {30'h0, light}, {30'h0, e});
    if (light !== e) finish_test();
  endtask
  always @(posedge clk_sys_i) if (wake === 1'b1) wk <= wk + 1;
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys_i);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    {rst_b_i, doze_i, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {want, awaddr, araddr, lag, wstrb, wdata} = 0;
    rs = 32'hd2e5;
    wk = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(8'hE8, 2'h0);
    chk("sel_rst", rdv, 0);
    rd(8'hF0, 2'h0);
    chk("g0_rst", rdv, 0);
    rd(8'hF8, 2'h0);
    chk("g1_rst", rdv, 0);
    wr(8'hEC, 8'hFF, 2'h0);
    rd(8'hEC, 2'h0);
    chk("g0_up", rdv, 0);
    wr(8'hF4, 8'hFF, 2'h0);
    rd(8'hF4, 2'h0);
    chk("g1_up", rdv, 0);
    // unmapped index answers with an error
    wr(8'h04, 8'h11, 2'h2);
    rd(8'h04, 2'h2);
    for (i = 0; i < 4; i++)
    begin
      rs = nx(rs);
      wr(8'hF0, rs[7:0], 2'h0);
      rd(8'hF0, 2'h0);
      chk("g0_rw", rdv, {24'h0, rs[7:0]});
      wr(8'hF8, rs[15:8], 2'h0);
      rd(8'hF8, 2'h0);
      chk("g1_rw", rdv, {24'h0, rs[15:8]});
      wr(8'hD0, rs[23:16], 2'h0);
      rd(8'hD0, 2'h0);
      chk("keys_rw", rdv, {24'h0, rs[23:16]});
    end
    wr(8'hE8, 8'h44, 2'h0);
    pr(4, 1);
    wl(2'h3, 0);
    pr(4, 0);
    wl(2'h0, 0);
    for (i = 0; i < 8; i++)
    begin
      wr(8'hE8, {4'h8, i[3:0]}, 2'h0);
      pr((i + 1) % 8, 1);
      wl(2'h0, 1);
      pr(i, 1);
      wl(2'h1, 0);
      pr(i, 0);
      pr((i + 1) % 8, 0);
      wl(2'h0, 0);
    end
    wr(8'hF0, 8'h03, 2'h0);
    wr(8'hF8, 8'h80, 2'h0);
    wr(8'hE8, 8'hDC, 2'h0);
    pr(1, 1);
    wl(2'h1, 0);
    pr(7, 1);
    wl(2'h3, 0);
    pr(1, 0);
    pr(7, 0);
    wl(2'h0, 0);
    pr(2, 1);
    wl(2'h0, 1);
    pr(2, 0);
    pr(0, 1);
    wl(2'h1, 0);
    pr(0, 0);
    wl(2'h0, 0);
    wr(8'hE8, 8'h04, 2'h0);
    pr(4, 1);
    wl(2'h1, 0);
    wr(8'hE8, 8'h0E, 2'h0);
    pr(4, 0);
    wl(2'h1, 1);
    wr(8'hE8, 8'h04, 2'h0);
    pr(4, 1);
    pr(4, 0);
    wl(2'h0, 0);
    wr(8'hFC, 8'h02, 2'h0);
    wr(8'hE8, 8'h44, 2'h0);
    pr(4, 1);
    wl(2'h2, 1);
    pr(4, 0);
    wl(2'h0, 0);
    wr(8'hFC, 8'h03, 2'h0);
    doze_i <= 1'b1;
    wr(8'hCC, 8'h00, 2'h0);
    k = wk;
    pr(3, 1);
    pr(3, 0);
    wl(2'h0, 1);
    chk("wake_any", wk > k, 1);
    wr(8'hCC, 8'h07, 2'h0);
    k = wk;
    pr(3, 1);
    pr(3, 0);
    wl(2'h0, 1);
    chk("wake_off", wk - k, 0);
    wr(8'hCC, 8'h02, 2'h0);
    wr(8'hD8, 8'h52, 2'h0);
    k = wk;
    pr(2, 1);
    pr(2, 0);
    pr(3, 1);
    pr(3, 0);
    wl(2'h0, 1);
    pr(2, 1);
    pr(2, 0);
    wl(2'h0, 1);
    chk("wake_part", wk - k, 0);
    pr(5, 1);
    wl(2'h0, 1);
    chk("wake_held", wk - k, 0);
    pr(5, 0);
    wl(2'h0, 1);
    chk("wake_seq", wk - k, 1);
    finish_test();
  end
endmodule // tb_touch_event_light_mapping
`default_nettype wire
